// ===== logic/i2c_serial_eeprom_slave.sv
// Purpose: Two-wire serial slave of a 128K x 8 EEPROM with an identification page.
// Assumes: SCL and SDA are sampled by ref_clk, several cycles per SCL phase.
// Notes:   Bytes land in storage when acknowledged; the busy window follows the stop.
//
// Overview of operation
// - SDA changes only while SCL is low
// - SDA falling with SCL high is start
// - Eight-bit words, acknowledge on ninth clock
// - Start, nine clocks, start, stop recovers device
// - Device type nibble must match to respond
// - Two address bits compare with strap pins
// - Seventh address bit is top word-address bit
// - Eighth bit selects direction; mismatch goes standby
// - Write-protect pin high blocks array writes
// - Byte write: high, low address, data, stop
// - Busy after write stop, ignores all inputs
// - Self-timed write cycle ends within 5 ms
// - Page write accepts further acknowledged data bytes
// - Page write wraps within 256-byte page
// - Identification page write uses low address byte
// - Locked identification page refuses and ignores data
// - Lock command with region bit and bit1
// - Address counter holds last address plus one
// - Current address read sends byte at counter
// - Master acknowledge continues read, wraps array end
// - Identification read uses low address byte only
// - Truncated identification write reports lock by acknowledge
`timescale 1ns/1ps
`default_nettype none
`include "eeprom_defines.svh"

module i2c_serial_eeprom_slave #(
	parameter int WRITE_CYCLES = `WRITE_CYCLES
) (
	// Clock, reset and enable
	input  wire logic ref_clk,
	input  wire logic rst,
	input  wire logic clk_en,
	// Two-wire bus
	input  wire logic scl_pin,
	input  wire logic sda_in,
	output logic      sda_out,
	output logic      sda_oe,
	// Strap and protect pins
	input  wire logic write_protect_pin,
	input  wire logic addr_strap_low,
	input  wire logic addr_strap_high,
	// Status
	output logic      write_busy,
	output logic      id_page_locked,
	output logic      bus_active
);

	import eeprom_pkg::*;

	localparam int BUSY_W = $clog2(WRITE_CYCLES + 1);

	// Synchronised pins and edge history
	logic [`PIN_SYNC_W-1:0]  pins_sync;
	logic                    scl;
	logic                    sda;
	logic                    wp;
	logic                    strap_hi;
	logic                    strap_lo;
	logic                    scl_prev;
	logic                    sda_prev;
	logic                    scl_rise;
	logic                    scl_fall;
	logic                    start_cond;
	logic                    stop_cond;

	// Protocol state
	slave_state_type         state;
	logic [`BIT_CNT_W-1:0]   bit_cnt;
	logic                    ack_phase;
	logic [`BYTE_W-1:0]      shift_in;
	logic [`BYTE_W-1:0]      shift_out;
	logic [`WORD_ADDR_W-1:0] word_addr;
	logic [`WORD_ADDR_W-1:0] next_read_addr;
	logic                    id_sel;
	logic                    read_dir;
	logic                    master_ack;
	logic                    write_pending;
	logic                    lock_pending;
	logic [BUSY_W-1:0]       busy_cnt;

	// Decoded conditions
	logic                    dev_match;
	logic                    byte_done;
	logic                    data_byte_done;
	logic                    lock_cmd;
	logic                    id_write_ok;
	logic                    wdata_ack;
	logic                    arr_we;
	logic                    id_we;
	logic                    prog_start;
	logic [`BYTE_W-1:0]      arr_rdata;
	logic [`BYTE_W-1:0]      id_rdata;
	logic [`BYTE_W-1:0]      rd_byte;

	pin_sync #(
		.WIDTH (`PIN_SYNC_W)
	) u_pin_sync (
		.ref_clk  (ref_clk),
		.rst      (rst),
		.clk_en   (clk_en),
		.async_in ({scl_pin, sda_in, write_protect_pin, addr_strap_high, addr_strap_low}),
		.sync_out (pins_sync)
	);

	assign scl      = pins_sync[4];
	assign sda      = pins_sync[3];
	assign wp       = pins_sync[2];
	assign strap_hi = pins_sync[1];
	assign strap_lo = pins_sync[0];

	// Edge history on the synchronised copies
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			scl_prev <= 1'b0;
			sda_prev <= 1'b0;
		end else if (clk_en) begin
			scl_prev <= scl;
			sda_prev <= sda;
		end
	end

	assign scl_rise   = scl & ~scl_prev;
	assign scl_fall   = ~scl & scl_prev;
	// SDA moving while SCL stays high is a bus condition, never data
	assign start_cond = scl & scl_prev & sda_prev & ~sda;
	assign stop_cond  = scl & scl_prev & ~sda_prev & sda;

	// Device type nibble and strap bits must all agree
	assign dev_match = ((shift_in[`DEV_TYPE_HI:`DEV_TYPE_LO] == `DEV_TYPE_ARRAY) ||
	                    (shift_in[`DEV_TYPE_HI:`DEV_TYPE_LO] == `DEV_TYPE_ID)) &&
	                   (shift_in[`DEV_STRAP_HIGH] == strap_hi) &&
	                   (shift_in[`DEV_STRAP_LOW] == strap_lo);

	assign byte_done      = scl_fall && !ack_phase && (bit_cnt == `ACK_BIT_CNT);
	assign data_byte_done = byte_done && (state == st_wdata);
	assign lock_cmd       = id_sel && word_addr[`ID_REGION_BIT];
	assign id_write_ok    = id_sel && !word_addr[`ID_REGION_BIT] && !id_page_locked;
	// Only a locked identification page write withholds the data acknowledge
	assign wdata_ack      = !(id_sel && !word_addr[`ID_REGION_BIT] && id_page_locked);
	assign arr_we         = data_byte_done && !id_sel && !wp;
	assign id_we          = data_byte_done && id_write_ok;
	assign prog_start     = stop_cond && !write_busy && (write_pending || lock_pending);

	// Array reads wrap at the end of the array, identification reads inside the page
	always_comb begin
		next_read_addr = word_addr + 1'b1;
		if (id_sel) begin
			next_read_addr = {word_addr[`WORD_ADDR_W-1:`PAGE_ADDR_W],
			                  word_addr[`PAGE_ADDR_W-1:0] + 1'b1};
		end
	end

	assign rd_byte = id_sel ? id_rdata : arr_rdata;

	byte_mem #(
		.ADDR_W (`WORD_ADDR_W),
		.DATA_W (`BYTE_W)
	) u_array (
		.ref_clk (ref_clk),
		.clk_en  (clk_en),
		.we      (arr_we),
		.waddr   (word_addr),
		.wdata   (shift_in),
		.raddr   (word_addr),
		.rdata   (arr_rdata)
	);

	byte_mem #(
		.ADDR_W (`PAGE_ADDR_W),
		.DATA_W (`BYTE_W)
	) u_id_page (
		.ref_clk (ref_clk),
		.clk_en  (clk_en),
		.we      (id_we),
		.waddr   (word_addr[`PAGE_ADDR_W-1:0]),
		.wdata   (shift_in),
		.raddr   (word_addr[`PAGE_ADDR_W-1:0]),
		.rdata   (id_rdata)
	);

	// Protocol engine
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			state         <= st_idle;
			bit_cnt       <= '0;
			ack_phase     <= 1'b0;
			shift_in      <= '0;
			shift_out     <= '0;
			word_addr     <= '0;
			id_sel        <= 1'b0;
			read_dir      <= 1'b0;
			master_ack    <= 1'b0;
			write_pending <= 1'b0;
			lock_pending  <= 1'b0;
			sda_oe        <= 1'b0;
		end else if (clk_en) begin
			if (write_busy) begin
				// Deaf and silent while programming
				state         <= st_idle;
				sda_oe        <= 1'b0;
				ack_phase     <= 1'b0;
				write_pending <= 1'b0;
				lock_pending  <= 1'b0;
			end else if (start_cond) begin
				// Also ends any half-done frame, which is what recovery relies on
				state     <= st_dev;
				bit_cnt   <= '0;
				ack_phase <= 1'b0;
				sda_oe    <= 1'b0;
			end else if (stop_cond) begin
				state         <= st_idle;
				sda_oe        <= 1'b0;
				ack_phase     <= 1'b0;
				write_pending <= 1'b0;
				lock_pending  <= 1'b0;
			end else if (scl_rise && state != st_idle) begin
				if (!ack_phase) begin
					shift_in <= {shift_in[`BYTE_W-2:0], sda};
					bit_cnt  <= bit_cnt + 1'b1;
				end else if (state == st_rdata) begin
					// Counter moves past the byte just sent even on a refusal
					master_ack <= ~sda;
					word_addr  <= next_read_addr;
				end
			end else if (scl_fall) begin
				unique case (state)
					st_idle: begin
						sda_oe <= 1'b0;
					end
					st_rdata: begin
						if (!ack_phase) begin
							if (bit_cnt == `ACK_BIT_CNT) begin
								sda_oe    <= 1'b0;
								ack_phase <= 1'b1;
							end else begin
								sda_oe    <= ~shift_out[`BYTE_W-1];
								shift_out <= {shift_out[`BYTE_W-2:0], 1'b0};
							end
						end else begin
							ack_phase <= 1'b0;
							bit_cnt   <= '0;
							if (master_ack) begin
								sda_oe    <= ~rd_byte[`BYTE_W-1];
								shift_out <= {rd_byte[`BYTE_W-2:0], 1'b0};
							end else begin
								sda_oe <= 1'b0;
								state  <= st_idle;
							end
						end
					end
					st_dev, st_addrh, st_addrl, st_wdata: begin
						if (!ack_phase) begin
							if (bit_cnt == `ACK_BIT_CNT) begin
								ack_phase <= 1'b1;
								if (state == st_dev) begin
									sda_oe <= dev_match;
									if (dev_match) begin
										id_sel   <= (shift_in[`DEV_TYPE_HI:`DEV_TYPE_LO] == `DEV_TYPE_ID);
										read_dir <= shift_in[`DEV_RW];
										if (!shift_in[`DEV_RW]) begin
											word_addr[`WORD_ADDR_W-1] <= shift_in[`DEV_TOP_ADDR];
										end
									end
								end else if (state == st_addrh) begin
									sda_oe <= 1'b1;
									word_addr[`WORD_ADDR_W-2:`PAGE_ADDR_W] <= shift_in;
								end else if (state == st_addrl) begin
									sda_oe <= 1'b1;
									word_addr[`PAGE_ADDR_W-1:0] <= shift_in;
								end else begin
									sda_oe <= wdata_ack;
									if (arr_we || id_we) begin
										write_pending <= 1'b1;
									end
									if (lock_cmd && shift_in[`LOCK_DATA_BIT] && !id_page_locked) begin
										lock_pending <= 1'b1;
									end
									// Page roll-over keeps the upper address bits
									word_addr[`PAGE_ADDR_W-1:0] <= word_addr[`PAGE_ADDR_W-1:0] + 1'b1;
								end
							end
						end else begin
							ack_phase <= 1'b0;
							bit_cnt   <= '0;
							if (!sda_oe) begin
								state <= st_idle;
							end else if (state == st_dev && read_dir) begin
								// First read byte is already waiting at the counter
								state     <= st_rdata;
								sda_oe    <= ~rd_byte[`BYTE_W-1];
								shift_out <= {rd_byte[`BYTE_W-2:0], 1'b0};
							end else begin
								sda_oe <= 1'b0;
								if (state == st_dev) begin
									state <= st_addrh;
								end else if (state == st_addrh) begin
									state <= st_addrl;
								end else begin
									state <= st_wdata;
								end
							end
						end
					end
				endcase
			end
		end
	end

	// Self-timed programming window
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			write_busy <= 1'b0;
			busy_cnt   <= '0;
		end else if (clk_en) begin
			if (prog_start) begin
				write_busy <= 1'b1;
				busy_cnt   <= BUSY_W'(WRITE_CYCLES - 1);
			end else if (write_busy) begin
				if (busy_cnt == '0) begin
					write_busy <= 1'b0;
				end else begin
					busy_cnt <= busy_cnt - 1'b1;
				end
			end
		end
	end

	// Lock flag, set only at the stop that ends a lock command
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			id_page_locked <= 1'b0;
		end else if (clk_en) begin
			if (prog_start && lock_pending) begin
				id_page_locked <= 1'b1;
			end
		end
	end

	// Bus drive is open drain: only ever a low
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			sda_out    <= 1'b0;
			bus_active <= 1'b0;
		end else if (clk_en) begin
			sda_out    <= 1'b0;
			bus_active <= (state != st_idle);
		end
	end

endmodule : i2c_serial_eeprom_slave

`default_nettype wire

// ===== logic/eeprom_defines.svh
// Purpose: Shared constants of the two-wire EEPROM slave.
// Assumes: Byte-wide storage, 17-bit word address, 20 MHz system clock.
// Notes:   Included by bare name; holds definitions only.
`ifndef EEPROM_DEFINES_SVH
`define EEPROM_DEFINES_SVH

// Word and address layout
`define BYTE_W            8
`define BIT_CNT_W         4
`define WORD_ADDR_W       17
`define PAGE_ADDR_W       8
`define ACK_BIT_CNT       4'h8

// Device address word fields
`define DEV_TYPE_HI       7
`define DEV_TYPE_LO       4
`define DEV_STRAP_HIGH    3
`define DEV_STRAP_LOW     2
`define DEV_TOP_ADDR      1
`define DEV_RW            0
`define DEV_TYPE_ARRAY    4'hA
`define DEV_TYPE_ID       4'hB

// Identification page control
`define ID_REGION_BIT     10
`define LOCK_DATA_BIT     1

// Self-timed write cycle
`define CLK_FREQ_MHZ      20
`define WRITE_TIME_US     5000
`define WRITE_CYCLES      (`WRITE_TIME_US * `CLK_FREQ_MHZ)

// Synchronised pin count
`define PIN_SYNC_W        5

`endif

// ===== logic/eeprom_pkg.sv
// Purpose: Types of the two-wire EEPROM slave.
// Assumes: Constants live in eeprom_defines.svh.
// Notes:   One-hot protocol states.
`default_nettype none

package eeprom_pkg;

	typedef enum logic [5:0] {
		st_idle  = 6'h01,
		st_dev   = 6'h02,
		st_addrh = 6'h04,
		st_addrl = 6'h08,
		st_wdata = 6'h10,
		st_rdata = 6'h20
	} slave_state_type;

endpackage : eeprom_pkg

`default_nettype wire

// ===== logic/pin_sync.sv
// Purpose: Two-flop synchroniser for pins from outside the clock domain.
// Assumes: Each bit is an independent level.
// Notes:   Only the second stage is visible outside.
`timescale 1ns/1ps
`default_nettype none

module pin_sync #(
	parameter int WIDTH = 1
) (
	// Clock and control
	input  wire logic             ref_clk,
	input  wire logic             rst,
	input  wire logic             clk_en,
	// Pins
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);

	genvar i;
	generate
		for (i = 0; i < WIDTH; i++) begin : g_bit
			logic meta;
			always_ff @(posedge ref_clk) begin
				if (rst) begin
					meta        <= 1'b0;
					sync_out[i] <= 1'b0;
				end else if (clk_en) begin
					meta        <= async_in[i];
					sync_out[i] <= meta;
				end
			end
		end
	endgenerate

endmodule : pin_sync

`default_nettype wire

// ===== logic/byte_mem.sv
// Purpose: Byte storage with one write port and a registered read port.
// Assumes: Contents are not reset; read data lag the address by one cycle.
// Notes:   Used for the main array and the identification page.
`timescale 1ns/1ps
`default_nettype none

module byte_mem #(
	parameter int ADDR_W = 8,
	parameter int DATA_W = 8
) (
	// Clock
	input  wire logic              ref_clk,
	input  wire logic              clk_en,
	// Write port
	input  wire logic              we,
	input  wire logic [ADDR_W-1:0] waddr,
	input  wire logic [DATA_W-1:0] wdata,
	// Read port
	input  wire logic [ADDR_W-1:0] raddr,
	output logic      [DATA_W-1:0] rdata
);

	logic [DATA_W-1:0] store [0:(1 << ADDR_W)-1];

	always_ff @(posedge ref_clk) begin
		if (clk_en) begin
			if (we) begin
				store[waddr] <= wdata;
			end
			rdata <= store[raddr];
		end
	end

endmodule : byte_mem

`default_nettype wire

// ===== testbench/i2c_master_model.sv
// Purpose: Behavioural two-wire bus master.
// Assumes: 400 ns SCL period; the SDA wire has a pull-up.
// Notes:   Lets SDA go while idle; changes it with SCL low except in start_c and stop_c, which move it with SCL high.
`timescale 1ns/1ps
`default_nettype none

module i2c_master_model (
	// Bus
	output var logic scl,
	output var logic pull,
	input  wire logic sda
);
	initial begin
		scl = 1'b1;
		pull = 1'b0;
	end

	task automatic bit_io(input logic b, output logic r);
		pull = !b;
		#25 scl = 1'b1;
		#100 r = sda;
		#100 scl = 1'b0;
		#175;
	endtask : bit_io

	task automatic start_c();
		pull = 1'b0;
		#25 scl = 1'b1;
		#100 pull = 1'b1;
		#100 scl = 1'b0;
		#175;
	endtask : start_c

	task automatic stop_c();
		pull = 1'b1;
		#25 scl = 1'b1;
		#100 pull = 1'b0;
		#100;
	endtask : stop_c

	task automatic put(input logic [7:0] b, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_io(b[i], r);
		end
		bit_io(1'b1, r);
		ack = !r;
	endtask : put

	task automatic get(input logic mack, output logic [7:0] b);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_io(1'b1, b[i]);
		end
		bit_io(!mack, r);
	endtask : get
endmodule : i2c_master_model

`default_nettype wire

// ===== testbench/i2c_serial_eeprom_slave_chk.sv
// Purpose: Port checker of the two-wire EEPROM slave.
// Assumes: One clock domain, rst synchronous and active high.
// Notes:   Bound to every instance of the slave.
`timescale 1ns/1ps
`default_nettype none

module i2c_serial_eeprom_slave_chk #(
	parameter int WRITE_CYCLES = 100000
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// Watched pins
	input wire logic scl_pin,
	input wire logic sda_out,
	input wire logic sda_oe,
	input wire logic write_busy,
	input wire logic id_page_locked,
	input wire logic bus_active
);
	int busy_cnt;

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);

	always_ff @(posedge ref_clk) begin
		if (rst || !write_busy) begin
			busy_cnt <= 0;
		end else begin
			busy_cnt <= busy_cnt + 1;
		end
	end

	property p_rst_clear;
		disable iff (1'b0) rst |=> !sda_oe && !write_busy && !id_page_locked && !bus_active;
	endproperty
	property p_oe_low;
		sda_oe |-> !sda_out;
	endproperty
	property p_oe_rise;
		$rose(sda_oe) |-> !$past(scl_pin, 2);
	endproperty
	property p_busy_quiet;
		write_busy |-> !sda_oe;
	endproperty
	property p_busy_idle;
		write_busy && $past(write_busy) |-> !bus_active;
	endproperty
	property p_busy_max;
		busy_cnt <= WRITE_CYCLES;
	endproperty
	property p_busy_min;
		$fell(write_busy) && !$past(rst) |-> busy_cnt >= WRITE_CYCLES - 2;
	endproperty
	property p_lock_busy;
		$rose(id_page_locked) |-> ##[0:2] write_busy;
	endproperty
	property p_lock_keep;
		id_page_locked |=> id_page_locked;
	endproperty

	a_rst_clear: assert property (p_rst_clear) else $error("outputs not cleared by reset");
	a_oe_low: assert property (p_oe_low) else $error("data driven high");
	a_oe_rise: assert property (p_oe_rise) else $error("data pulled while clock high");
	a_busy_quiet: assert property (p_busy_quiet) else $error("data pulled while busy");
	a_busy_idle: assert property (p_busy_idle) else $error("bus active while busy");
	a_busy_max: assert property (p_busy_max) else $error("write cycle too long");
	a_busy_min: assert property (p_busy_min) else $error("write cycle too short");
	a_lock_busy: assert property (p_lock_busy) else $error("lock without write cycle");
	a_lock_keep: assert property (p_lock_keep) else $error("lock dropped");

	c_busy: cover property ($rose(write_busy));
	c_lock: cover property ($rose(id_page_locked));
	c_drive: cover property ($rose(sda_oe));
endmodule : i2c_serial_eeprom_slave_chk

bind i2c_serial_eeprom_slave i2c_serial_eeprom_slave_chk #(.WRITE_CYCLES(WRITE_CYCLES)) i2c_serial_eeprom_slave_chk_i (
	.ref_clk(ref_clk), .rst(rst), .scl_pin(scl_pin), .sda_out(sda_out), .sda_oe(sda_oe),
	.write_busy(write_busy), .id_page_locked(id_page_locked), .bus_active(bus_active));

`default_nettype wire

// ===== testbench/tb_i2c_serial_eeprom_slave.sv
// Purpose: Self-checking bench of the two-wire EEPROM slave.
// Assumes: Straps at high=1, low=0, so the array address is 0xA8.
// Notes:   Write cycle shortened to WR clocks.
`timescale 1ns/1ps
`default_nettype none

module tb_i2c_serial_eeprom_slave;
	localparam int WR = 200;
	logic       ref_clk;
	logic       rst;
	logic       wp;
	logic [1:0] strap;
	logic       busy;
	logic       locked;
	logic       act;
	logic       oe;
	logic       so;
	logic       scl;
	logic       pull;
	logic       a;
	logic [7:0] d;
	wire logic  sda;
	int         num_errors;
	int         total_checks;

	assign sda = !(oe || pull);

	i2c_master_model i2c_master_model_i (.scl(scl), .pull(pull), .sda(sda));

	i2c_serial_eeprom_slave #(.WRITE_CYCLES(WR)) i2c_serial_eeprom_slave_i (
		.ref_clk(ref_clk), .rst(rst), .clk_en(1'b1), .scl_pin(scl), .sda_in(sda), .sda_out(so),
		.sda_oe(oe), .write_protect_pin(wp), .addr_strap_low(strap[0]), .addr_strap_high(strap[1]),
		.write_busy(busy), .id_page_locked(locked), .bus_active(act));

	initial begin
		ref_clk = 1'b0;
		forever #25 ref_clk = ~ref_clk;
	end

	task automatic cmp(input logic [7:0] g, input logic [7:0] e);
		total_checks++;
		if (g !== e) begin
			num_errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : cmp

	task automatic send(input logic [7:0] b, input logic e);
		i2c_master_model_i.put(b, a);
		cmp({7'h00, a}, {7'h00, e});
	endtask : send

	task automatic addr(input logic [7:0] dv, input logic [7:0] hi, input logic [7:0] lo);
		i2c_master_model_i.start_c();
		send(dv, 1'b1);
		send(hi, 1'b1);
		send(lo, 1'b1);
	endtask : addr

	task automatic rd(input logic [7:0] dv, input logic [7:0] hi, input logic [7:0] lo, input logic [7:0] e);
		addr(dv, hi, lo);
		i2c_master_model_i.start_c();
		send(dv | 8'h01, 1'b1);
		i2c_master_model_i.get(1'b0, d);
		cmp(d, e);
		i2c_master_model_i.stop_c();
	endtask : rd

	task automatic wait_idle(input logic e);
		int n;
		n = 0;
		repeat (4) @(posedge ref_clk);
		#5;
		cmp({7'h00, busy}, {7'h00, e});
		if (e) begin
			i2c_master_model_i.start_c();
			send(8'hA8, 1'b0);
			i2c_master_model_i.stop_c();
		end
		while (busy === 1'b1 && n < WR + 10) begin
			@(posedge ref_clk);
			#5;
			n++;
		end
		cmp({7'h00, busy}, 8'h00);
	endtask : wait_idle

	task automatic t_page();
		addr(8'hA8, 8'h00, 8'hFF);
		send(8'h11, 1'b1);
		send(8'h22, 1'b1);
		send(8'h33, 1'b1);
		i2c_master_model_i.stop_c();
		wait_idle(1'b1);
		rd(8'hA8, 8'h00, 8'h00, 8'h22);
		i2c_master_model_i.start_c();
		send(8'hA9, 1'b1);
		i2c_master_model_i.get(1'b0, d);
		cmp(d, 8'h33);
		i2c_master_model_i.stop_c();
		$display("page test done");
	endtask : t_page

	task automatic t_write();
		addr(8'hAA, 8'hFF, 8'hFF);
		send(8'h5A, 1'b1);
		i2c_master_model_i.stop_c();
		wait_idle(1'b1);
		addr(8'hAA, 8'hFF, 8'hFF);
		i2c_master_model_i.start_c();
		send(8'hAB, 1'b1);
		i2c_master_model_i.get(1'b1, d);
		cmp(d, 8'h5A);
		i2c_master_model_i.get(1'b0, d);
		cmp(d, 8'h22);
		i2c_master_model_i.stop_c();
		$display("write test done");
	endtask : t_write

	task automatic t_wp();
		wp = 1'b1;
		addr(8'hA8, 8'h00, 8'h00);
		send(8'hEE, 1'b1);
		i2c_master_model_i.stop_c();
		wait_idle(1'b0);
		wp = 1'b0;
		rd(8'hA8, 8'h00, 8'h00, 8'h22);
		$display("protect test done");
	endtask : t_wp

	task automatic t_bad();
		logic [7:0] codes [3];
		codes = '{8'hA4, 8'hAC, 8'h28};
		foreach (codes[i]) begin
			i2c_master_model_i.start_c();
			send(codes[i], 1'b0);
			i2c_master_model_i.stop_c();
		end
		// Swapped straps: the word refused above must now match, the usual one not
		strap = 2'b01;
		i2c_master_model_i.start_c();
		send(8'hA4, 1'b1);
		i2c_master_model_i.stop_c();
		i2c_master_model_i.start_c();
		send(8'hA8, 1'b0);
		i2c_master_model_i.stop_c();
		strap = 2'b10;
		$display("address test done");
	endtask : t_bad

	task automatic t_id();
		addr(8'hB8, 8'h00, 8'h05);
		send(8'h96, 1'b1);
		i2c_master_model_i.stop_c();
		wait_idle(1'b1);
		rd(8'hB8, 8'hFB, 8'h05, 8'h96);
		addr(8'hB8, 8'h04, 8'h00);
		send(8'h02, 1'b1);
		i2c_master_model_i.stop_c();
		wait_idle(1'b1);
		cmp({7'h00, locked}, 8'h01);
		addr(8'hB8, 8'h00, 8'h05);
		send(8'h55, 1'b0);
		i2c_master_model_i.stop_c();
		rd(8'hB8, 8'h00, 8'h05, 8'h96);
		$display("id test done");
	endtask : t_id

	task automatic t_soft();
		addr(8'hA8, 8'h00, 8'h00);
		i2c_master_model_i.start_c();
		send(8'hA9, 1'b1);
		// Abandon the read while the slave pulls SDA low, then run the recovery
		i2c_master_model_i.start_c();
		for (int i = 6; i >= 0; i--) begin
			i2c_master_model_i.bit_io(1'b1, d[i]);
		end
		cmp({1'b0, d[6:0]}, 8'h22);
		repeat (2) i2c_master_model_i.bit_io(1'b1, a);
		i2c_master_model_i.start_c();
		i2c_master_model_i.stop_c();
		repeat (4) @(posedge ref_clk);
		#5;
		cmp({7'h00, act}, 8'h00);
		rd(8'hA8, 8'h00, 8'h01, 8'h33);
		$display("recovery test done");
	endtask : t_soft

	task automatic close_out();
		$display("checks=%0d errors=%0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : close_out

	initial begin
		#2000000;
		num_errors++;
		close_out();
	end

	initial begin
		rst = 1'b1;
		wp = 1'b0;
		strap = 2'b10;
		num_errors = 0;
		total_checks = 0;
		repeat (4) @(posedge ref_clk);
		#5 rst = 1'b0;
		repeat (4) @(posedge ref_clk);
		#5;
		t_page();
		t_write();
		t_wp();
		t_bad();
		t_id();
		t_soft();
		close_out();
	end
endmodule : tb_i2c_serial_eeprom_slave

`default_nettype wire
